// *** sfd_regs.vh ***
/*
  Opcodes, group codes, address field positions and timing counts for the
  serial flash command decoder. Assumes the includer needs only macros.
*/
// Functional notes
// - during a self-timed erase/program phase, status, ID and other-buffer commands still execute; protection cycles allow status and AB resume only.
// - page read, continuous read, protection/lockdown/security reads are read class.
// - erases, transfer, compare, buffer programs, program-through and rewrite are self-timed class.
// - buffer read, buffer write, status read and ID read are buffer class.
// - protection register erase/program, lockdown, security program are protection class.
// - D2 page read, E8/03/0B continuous reads.
// - D1/D3 slow buffer reads, D4/D6 normal buffer reads.
// - 83/86 program with erase, 88/89 program without erase.
// - 84/87 buffer writes, 82/85 program through buffer.
// - 81 page, 50 block, 7C sector erase; chip erase C7 94 80 9A.
// - prefix 3D 2A 7F then A9, 9A, CF, FC or 30.
// - 32 protection read, 35 lockdown read, 77 security read.
// - security program only from 9B 00 00 00.
// - 53/55 transfer, 60/61 compare, 58/59 rewrite.
// - AB resume, D7 status, 9F ID, B9 power-down.
// - legacy 54, 56, 52, 68, 57 still accepted.
// - binary mode: two don't-care bits, then 22-bit byte address MSB first.
// - fast continuous read takes one dummy byte; slow read none.
// - binary page ops drop low nine bits; block uses A21..A12, sector A21..A16.
// - 528 mode: reserved bit, 13-bit page, 10-bit byte address.
// - status reports busy during any self-timed cycle.
`ifndef SFD_REGS_VH
`define SFD_REGS_VH
// ==========================================
// Groups
`define SFD_GRP_NONE 3'h0
`define SFD_GRP_A 3'h1
`define SFD_GRP_B 3'h2
`define SFD_GRP_C 3'h3
`define SFD_GRP_D 3'h4
`define SFD_GRP_X 3'h5
// ==========================================
// Single-byte opcodes
`define SFD_OP_PGRD 8'hd2
`define SFD_OP_CRLEG 8'he8
`define SFD_OP_CRSLOW 8'h03
`define SFD_OP_CRFAST 8'h0b
`define SFD_OP_B1RDS 8'hd1
`define SFD_OP_B2RDS 8'hd3
`define SFD_OP_B1RD 8'hd4
`define SFD_OP_B2RD 8'hd6
`define SFD_OP_B1PGE 8'h83
`define SFD_OP_B2PGE 8'h86
`define SFD_OP_B1PG 8'h88
`define SFD_OP_B2PG 8'h89
`define SFD_OP_B1WR 8'h84
`define SFD_OP_B2WR 8'h87
`define SFD_OP_B1PT 8'h82
`define SFD_OP_B2PT 8'h85
`define SFD_OP_PGER 8'h81
`define SFD_OP_BLER 8'h50
`define SFD_OP_SCER 8'h7c
`define SFD_OP_PRRD 8'h32
`define SFD_OP_LKRD 8'h35
`define SFD_OP_SRRD 8'h77
`define SFD_OP_B1XF 8'h53
`define SFD_OP_B2XF 8'h55
`define SFD_OP_B1CM 8'h60
`define SFD_OP_B2CM 8'h61
`define SFD_OP_B1RW 8'h58
`define SFD_OP_B2RW 8'h59
`define SFD_OP_RESUME 8'hab
`define SFD_OP_STAT 8'hd7
`define SFD_OP_ID 8'h9f
`define SFD_OP_PDOWN 8'hb9
`define SFD_OP_LB1RD 8'h54
`define SFD_OP_LB2RD 8'h56
`define SFD_OP_LPGRD 8'h52
`define SFD_OP_LCRD 8'h68
`define SFD_OP_LSTAT 8'h57
// ==========================================
// Multi-byte sequences
`define SFD_SEQ_CHIPER 32'hc794_809a
`define SFD_SEQ_SECPG 32'h9b00_0000
`define SFD_SEQ_PROT 24'h3d2a_7f
`define SFD_PF_EN 8'ha9
`define SFD_PF_DIS 8'h9a
`define SFD_PF_ERASE 8'hcf
`define SFD_PF_PROG 8'hfc
`define SFD_PF_LOCK 8'h30
// ==========================================
// Address fields
`define SFD_ADDR_W 22
`define SFD_PAGE_W 13
`define SFD_BYTE_W 10
`define SFD_PAGE_DROP 9
`define SFD_BLOCK_LSB 12
`define SFD_SECTOR_LSB 16
// ==========================================
// Timing
`define SFD_BUSY_NS 20000
`define SFD_CLK_NS 10
`define SFD_BUSY_CYC (`SFD_BUSY_NS / `SFD_CLK_NS)
`endif

// *** sfd_sync.v ***
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module sfd_sync (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Pin in, filtered level and edges out
  input wire pin,
  output reg level,
  output reg rise,
  output reg fall
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      rise <= 1'b0;
      fall <= 1'b0;
      // Change counts only once stages two and three agree
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise <= s3;
        fall <= ~s3;
      end
    end
  end
endmodule

// *** sfd_busy.v ***
/*
  Self-timed phase counter. Assumes start is a one-cycle pulse.
*/
`timescale 1ns/1ns
module sfd_busy #(
  parameter CYCLES = 2000
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire start,
  output reg busy
);
  reg [31:0] count;
  always @(posedge clk) begin
    if (srst) begin
      count <= 32'h0000_0000;
      busy <= 1'b0;
    end else if (start) begin
      count <= CYCLES;
      busy <= 1'b1;
    end else if (count > 32'h0000_0001) begin
      count <= count - 32'h0000_0001;
    end else begin
      count <= 32'h0000_0000;
      busy <= 1'b0;
    end
  end
endmodule

// *** sfd_decoder.v ***
/*
  Serial flash command decoder: shifts opcode and address bytes from the
  serial pins, classifies commands into four concurrency groups, tracks
  the self-timed phase and flags disallowed commands.
  Assumes serial pins are asynchronous and sampled at the 100 MHz clock.
*/
`timescale 1ns/1ns
`include "sfd_regs.vh"
module sfd_decoder #(
  parameter BUSY_CYCLES = `SFD_BUSY_CYC
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Serial pins
  input wire cs_n,
  input wire sck,
  input wire si,
  // Configuration
  input wire binary_page,
  // Decoded command
  output reg cmd_valid,
  output reg [7:0] cmd_code,
  output reg [7:0] cmd_final,
  output reg [2:0] cmd_group,
  output reg cmd_buf2,
  output reg cmd_dummy,
  output reg [21:0] cmd_addr,
  output reg [12:0] cmd_page,
  output reg [9:0] cmd_byte,
  output reg cmd_reject,
  // State
  output reg busy,
  output reg [2:0] active_group,
  output reg active_buf2,
  output reg read_active,
  output reg powered_down
);
  // ==========================================
  // Pin synchronisers
  wire cs_sel;
  wire cs_rise;
  wire cs_fall;
  wire sck_rise;
  wire si_lvl;
  // Select level, not the pin: reset value matches idle, so no false edge
  sfd_sync u_cs (
    .clk(clk),
    .srst(srst),
    .pin(~cs_n),
    .level(cs_sel),
    .rise(cs_fall),
    .fall(cs_rise)
  );
  sfd_sync u_sck (
    .clk(clk),
    .srst(srst),
    .pin(sck),
    .level(),
    .rise(sck_rise),
    .fall()
  );
  sfd_sync u_si (
    .clk(clk),
    .srst(srst),
    .pin(si),
    .level(si_lvl),
    .rise(),
    .fall()
  );

  // ==========================================
  // Self-timed phase timer
  reg timer_start;
  wire timer_busy;
  sfd_busy #(
    .CYCLES(BUSY_CYCLES)
  ) u_busy (
    .clk(clk),
    .srst(srst),
    .start(timer_start),
    .busy(timer_busy)
  );

  // ==========================================
  // Shifter
  reg [31:0] shreg;
  reg [5:0] bitcnt;
  reg framed;
  reg launch;
  reg [31:0] next_shreg;

  always @* begin
    next_shreg = {shreg[30:0], si_lvl};
  end

  // ==========================================
  // Classification of the first byte
  reg [2:0] grp;
  reg buf2;
  reg fast;
  reg multi;
  reg addr_cmd;
  reg selftimed;
  always @* begin
    grp = `SFD_GRP_X;
    buf2 = 1'b0;
    fast = 1'b0;
    multi = 1'b0;
    addr_cmd = 1'b1;
    selftimed = 1'b0;
    case (shreg[31:24])
      `SFD_OP_PGRD, `SFD_OP_CRLEG, `SFD_OP_CRSLOW: grp = `SFD_GRP_A;
      `SFD_OP_CRFAST: begin
        grp = `SFD_GRP_A;
        fast = 1'b1;
      end
      `SFD_OP_PRRD, `SFD_OP_LKRD, `SFD_OP_SRRD: grp = `SFD_GRP_A;
      `SFD_OP_LPGRD, `SFD_OP_LCRD: grp = `SFD_GRP_A;
      `SFD_OP_B1RDS, `SFD_OP_B1RD, `SFD_OP_B1WR, `SFD_OP_LB1RD: grp = `SFD_GRP_C;
      `SFD_OP_B2RDS, `SFD_OP_B2RD, `SFD_OP_B2WR, `SFD_OP_LB2RD: begin
        grp = `SFD_GRP_C;
        buf2 = 1'b1;
      end
      `SFD_OP_STAT, `SFD_OP_LSTAT, `SFD_OP_ID: begin
        grp = `SFD_GRP_C;
        addr_cmd = 1'b0;
      end
      `SFD_OP_B1PGE, `SFD_OP_B1PG, `SFD_OP_B1PT, `SFD_OP_B1XF, `SFD_OP_B1CM, `SFD_OP_B1RW,
      `SFD_OP_PGER, `SFD_OP_BLER, `SFD_OP_SCER: begin
        grp = `SFD_GRP_B;
        selftimed = 1'b1;
      end
      `SFD_OP_B2PGE, `SFD_OP_B2PG, `SFD_OP_B2PT, `SFD_OP_B2XF, `SFD_OP_B2CM, `SFD_OP_B2RW: begin
        grp = `SFD_GRP_B;
        buf2 = 1'b1;
        selftimed = 1'b1;
      end
      `SFD_OP_PDOWN, `SFD_OP_RESUME: begin
        grp = `SFD_GRP_NONE;
        addr_cmd = 1'b0;
      end
      default: begin
        multi = 1'b1;
        addr_cmd = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Four-byte sequences
  reg [2:0] mgrp;
  reg mst;
  always @* begin
    mgrp = `SFD_GRP_X;
    mst = 1'b0;
    if (shreg == `SFD_SEQ_CHIPER) begin
      mgrp = `SFD_GRP_B;
      mst = 1'b1;
    end else if (shreg == `SFD_SEQ_SECPG) begin
      mgrp = `SFD_GRP_D;
      mst = 1'b1;
    end else if (shreg[31:8] == `SFD_SEQ_PROT) begin
      case (shreg[7:0])
        `SFD_PF_ERASE, `SFD_PF_PROG, `SFD_PF_LOCK: begin
          mgrp = `SFD_GRP_D;
          mst = 1'b1;
        end
        `SFD_PF_EN, `SFD_PF_DIS: mgrp = `SFD_GRP_NONE;
        default: mgrp = `SFD_GRP_X;
      endcase
    end
  end

  // ==========================================
  // Concurrency check
  reg allowed;
  reg [2:0] eff_grp;
  always @* begin
    eff_grp = multi ? mgrp : grp;
    allowed = 1'b1;
    if (read_active) begin
      allowed = 1'b0;
    end else if (busy && active_group == `SFD_GRP_B) begin
      // buffer class still runs; other buffer only
      allowed = (eff_grp == `SFD_GRP_C) && (addr_cmd == 1'b0 || buf2 != active_buf2);
    end else if (busy && active_group == `SFD_GRP_D) begin
      allowed = (shreg[31:24] == `SFD_OP_STAT) || (shreg[31:24] == `SFD_OP_LSTAT);
    end
    if (eff_grp == `SFD_GRP_X) begin
      allowed = 1'b0;
    end
  end

  // ==========================================
  // One-byte commands ended by chip select
  reg short_cmd;
  reg short_ok;
  reg [2:0] short_grp;
  always @* begin
    short_cmd = (bitcnt == 6'h08);
    short_grp = `SFD_GRP_C;
    short_ok = !read_active && !(powered_down && shreg[7:0] != `SFD_OP_RESUME);
    case (shreg[7:0])
      `SFD_OP_STAT, `SFD_OP_LSTAT: short_grp = `SFD_GRP_C;
      // only status reads and resume in a protection cycle
      `SFD_OP_ID: short_ok = short_ok && !(busy && active_group == `SFD_GRP_D);
      // power commands; sleep refused while busy
      `SFD_OP_PDOWN: begin
        short_grp = `SFD_GRP_NONE;
        short_ok = short_ok && !busy;
      end
      `SFD_OP_RESUME: short_grp = `SFD_GRP_NONE;
      default: short_cmd = 1'b0;
    endcase
  end

  // ==========================================
  // Address decode
  reg [23:0] abytes;
  reg [21:0] next_addr;
  reg [12:0] next_page;
  reg [9:0] next_byte;
  always @* begin
    abytes = shreg[23:0];
    next_page = abytes[22:10];
    next_byte = abytes[9:0];
    next_addr = abytes[21:0];
    case (shreg[31:24])
      `SFD_OP_BLER: next_addr = {abytes[21:12], 12'h000};
      `SFD_OP_SCER: next_addr = {abytes[21:16], 16'h0000};
      `SFD_OP_SRRD: next_addr = 22'h00_0000;
      `SFD_OP_PGER, `SFD_OP_B1XF, `SFD_OP_B2XF, `SFD_OP_B1CM, `SFD_OP_B2CM,
      `SFD_OP_B1RW, `SFD_OP_B2RW: next_addr = {abytes[21:9], 9'h000};
      default: next_addr = abytes[21:0];
    endcase
  end

  // ==========================================
  // Main sequencer
  always @(posedge clk) begin
    if (srst) begin
      shreg <= 32'h0000_0000;
      bitcnt <= 6'h00;
      framed <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cmd_final <= 8'h00;
      cmd_group <= `SFD_GRP_NONE;
      cmd_buf2 <= 1'b0;
      cmd_dummy <= 1'b0;
      cmd_addr <= 22'h00_0000;
      cmd_page <= 13'h0000;
      cmd_byte <= 10'h000;
      cmd_reject <= 1'b0;
      busy <= 1'b0;
      active_group <= `SFD_GRP_NONE;
      active_buf2 <= 1'b0;
      read_active <= 1'b0;
      powered_down <= 1'b0;
      timer_start <= 1'b0;
      launch <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      timer_start <= 1'b0;
      // busy follows the self-timed phase
      // Plain copy of the timer, so busy stands exactly BUSY_CYCLES
      busy <= timer_busy;
      if (!timer_busy && !timer_start && !busy) begin
        active_group <= `SFD_GRP_NONE;
      end
      if (cs_fall) begin
        framed <= 1'b1;
        bitcnt <= 6'h00;
        shreg <= 32'h0000_0000;
      end else if (framed && cs_sel && sck_rise && bitcnt != 6'h20) begin
        shreg <= next_shreg;
        bitcnt <= bitcnt + 6'h01;
      end
      // Decode only once four bytes are in, not at end of frame
      if (framed && bitcnt == 6'h20) begin
        framed <= 1'b0;
        cmd_code <= shreg[31:24];
        cmd_final <= shreg[7:0];
        cmd_group <= multi ? mgrp : grp;
        cmd_buf2 <= buf2;
        cmd_dummy <= fast;
        cmd_addr <= binary_page ? next_addr : 22'h00_0000;
        cmd_page <= binary_page ? 13'h0000 : next_page;
        cmd_byte <= binary_page ? 10'h000 : next_byte;
        if (powered_down) begin
          cmd_reject <= 1'b1;
        end else if (allowed) begin
          cmd_valid <= 1'b1;
          if (eff_grp == `SFD_GRP_A) begin
            read_active <= 1'b1;
          end
          // self-timed work waits for select release
          launch <= multi ? mst : selftimed;
        end else begin
          cmd_reject <= 1'b1;
        end
      end
      // Short frame: single-byte commands end with chip select
      if (cs_rise && framed) begin
        framed <= 1'b0;
        if (short_cmd) begin
          cmd_code <= shreg[7:0];
          cmd_group <= short_grp;
          cmd_valid <= short_ok;
          cmd_reject <= ~short_ok;
          if (short_ok && shreg[7:0] == `SFD_OP_RESUME) begin
            powered_down <= 1'b0;
          end
          if (short_ok && shreg[7:0] == `SFD_OP_PDOWN) begin
            powered_down <= 1'b1;
          end
        end
      end
      // Self-timed phase starts at chip select release
      if (cs_rise) begin
        read_active <= 1'b0;
        launch <= 1'b0;
        // Refused commands never set launch, so they cannot start the timer
        if (launch && !busy) begin
          timer_start <= 1'b1;
          active_group <= cmd_group;
          active_buf2 <= cmd_buf2;
        end
      end
    end
  end
endmodule

// *** sfd_chk.sv ***
/*
  Port checks for the serial flash command decoder.
  Assumes binding to sfd_decoder: one clock, synchronous active-high reset.
*/
`timescale 1ns/1ns
module sfd_chk #(
  parameter BUSY_CYCLES = 2000
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Mode
  input wire binary_page,
  // Decoded command
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [2:0] cmd_group,
  input wire cmd_buf2,
  input wire cmd_dummy,
  input wire [21:0] cmd_addr,
  input wire cmd_reject,
  // State
  input wire busy,
  input wire [2:0] active_group,
  input wire active_buf2,
  input wire powered_down
);
  reg [15:0] busy_cnt;
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================
  // Busy length counter
  always @(posedge clk) begin
    if (srst || !busy)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_cnt + 16'h0001;
  end
  // ==========================================
  // Assertions
  a_pulse_once: assert property (cmd_valid |=> !cmd_valid && !cmd_reject)
    else $error("decode pulse longer than one cycle");
  a_one_verdict: assert property (!(cmd_valid && cmd_reject))
    else $error("command both accepted and refused");
  a_unknown_refused: assert property (cmd_valid |-> cmd_group != 3'h5)
    else $error("unknown command accepted");
  a_read_dummy: assert property (cmd_valid && (cmd_code == 8'h0b || cmd_code == 8'h03) |-> cmd_dummy == cmd_code[3])
    else $error("dummy byte flag wrong for continuous read");
  a_block_field: assert property (cmd_valid && binary_page && cmd_code == 8'h50 |-> cmd_addr[11:0] == 12'h000)
    else $error("block erase keeps low address bits");
  a_page_mode: assert property (cmd_valid && !binary_page |-> cmd_addr == 22'h00_0000)
    else $error("binary address driven in page mode");
  a_busy_short: assert property (busy |-> busy_cnt < BUSY_CYCLES)
    else $error("busy held too long");
  a_busy_full: assert property ($fell(busy) |-> busy_cnt == BUSY_CYCLES)
    else $error("busy dropped early");
  a_busy_cause: assert property ($rose(busy) |-> active_group == 3'h2 || active_group == 3'h4)
    else $error("busy started by a non self-timed group");
  a_b_window: assert property (busy && active_group == 3'h2 && cmd_valid |-> cmd_group == 3'h3 &&
    (cmd_code == 8'hd7 || cmd_code == 8'h57 || cmd_code == 8'h9f || cmd_buf2 != active_buf2))
    else $error("disallowed command accepted during erase or program");
  a_d_window: assert property (busy && active_group == 3'h4 && cmd_valid |-> cmd_code == 8'hd7 || cmd_code == 8'h57)
    else $error("non-status command accepted during protection cycle");
  a_sleep_wake: assert property ($past(powered_down) && cmd_valid |-> cmd_code == 8'hab)
    else $error("command other than resume accepted while asleep");
  c_busy_accept: cover property (busy && cmd_valid);
  c_busy_done: cover property ($fell(busy));
  c_sleep_refuse: cover property (powered_down && cmd_reject);
endmodule

// *** sfd_host.sv ***
/*
  Host model driving chip select, serial clock and data.
  Assumes clk is the decoder clock; serial clock runs at clk/11.
*/
`timescale 1ns/1ns
module sfd_host (
  // Clock
  input wire clk,
  // Serial pins
  output reg cs_n,
  output reg sck,
  output reg si
);
  integer i;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // one command per frame, MSB first
  task send(input [31:0] frame, input integer nbits);
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      for (i = 0; i < nbits; i = i + 1) begin
        @(posedge clk);
        si <= frame[31 - i];
        repeat (5) @(posedge clk);
        sck <= 1'b1;
        repeat (5) @(posedge clk);
        sck <= 1'b0;
      end
      repeat (5) @(posedge clk);
      cs_n <= 1'b1;
      // Released data line must not hold a stale bit
      si <= ~si;
    end
  endtask
endmodule

// *** serial_flash_command_decoder_test.sv ***
/*
  Self-checking bench for the serial flash command decoder.
  Assumes the host model sends one frame at a time.
*/
`timescale 1ns/1ns
module serial_flash_command_decoder_test;
  reg clk;
  reg srst;
  reg binary_page;
  wire cs_n, sck, si, cmd_valid, cmd_reject, cmd_buf2, cmd_dummy;
  wire busy, active_buf2, read_active, powered_down;
  wire [7:0] cmd_code, cmd_final;
  wire [2:0] cmd_group, active_group;
  wire [21:0] cmd_addr;
  wire [12:0] cmd_page;
  wire [9:0] cmd_byte;
  integer miscompares = 0, num_checks = 0, n_v = 0, n_r = 0, n_a = 0, cycles = 0, k;
  // Opcode and expected group, one-byte commands
  localparam [12*32-1:0] SINGLE = {12'hd21, 12'he81, 12'h031, 12'h0b1, 12'h321, 12'h351, 12'h771, 12'h521,
    12'h681, 12'h832, 12'h862, 12'h882, 12'h892, 12'h822, 12'h852, 12'h812, 12'h502, 12'h7c2, 12'h532,
    12'h552, 12'h602, 12'h612, 12'h582, 12'h592, 12'hd13, 12'hd33, 12'hd43, 12'hd63, 12'h843, 12'h873,
    12'h543, 12'h563};
  localparam [36*8-1:0] MULTI = {36'hc_7948_09a2, 36'h9_b000_0004, 36'h3_d2a7_fcf4, 36'h3_d2a7_ffc4,
    36'h3_d2a7_f304, 36'h3_d2a7_fa90, 36'h3_d2a7_f9a0, 36'hf_f000_0005};
  sfd_host i_sfd_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
  sfd_decoder #(.BUSY_CYCLES(1000)) i_sfd_decoder (.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
    .binary_page(binary_page), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_final(cmd_final),
    .cmd_group(cmd_group), .cmd_buf2(cmd_buf2), .cmd_dummy(cmd_dummy), .cmd_addr(cmd_addr),
    .cmd_page(cmd_page), .cmd_byte(cmd_byte), .cmd_reject(cmd_reject), .busy(busy),
    .active_group(active_group), .active_buf2(active_buf2), .read_active(read_active),
    .powered_down(powered_down));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_valid === 1'b1)
      n_v <= n_v + 1;
    if (cmd_reject === 1'b1)
      n_r <= n_r + 1;
    n_a <= n_a + (read_active === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  // ==========================================
  // Shared tasks
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask
  task wait_idle;
    integer t;
    begin
      t = 0;
      while (busy !== 1'b0 && t < 1100) begin
        @(posedge clk);
        t = t + 1;
      end
      check(busy, 0, "idle");
    end
  endtask
  task send_chk(input [31:0] f, input integer nb, input exp_v);
    integer v0, r0;
    begin
      v0 = n_v;
      r0 = n_r;
      i_sfd_host.send(f, nb);
      repeat (20) @(posedge clk);
      check(n_v - v0, exp_v, "accepted");
      check(n_r - r0, !exp_v, "refused");
    end
  endtask
  task classify(input [31:0] f, input [2:0] grp);
    integer a0;
    begin
      a0 = n_a;
      send_chk(f, 32, grp != 3'h5);
      check(n_a != a0, grp == 3'h1, "read open");
      check(read_active, 0, "read closed");
      check(cmd_group, grp, "group");
      check(cmd_code, f[31:24], "code");
      check(cmd_final, f[7:0], "final");
      if (f[31:24] == 8'h0b || f[31:24] == 8'h03)
        check(cmd_dummy, f[27], "dummy");
      check(busy, grp == 3'h2 || grp == 3'h4, "busy");
      wait_idle;
    end
  endtask
  task addr_one(input [7:0] op, input [23:0] a, input [21:0] exp_a);
    begin
      send_chk({op, a}, 32, 1'b1);
      check(cmd_addr, exp_a, "address");
      wait_idle;
    end
  endtask
  // ==========================================
  // Scenarios
  task classify_all;
    begin
      for (k = 0; k < 32; k = k + 1)
        classify({SINGLE[k*12+4 +: 8], 24'h00_0000}, SINGLE[k*12 +: 3]);
      for (k = 0; k < 8; k = k + 1)
        classify(MULTI[k*36+4 +: 32], MULTI[k*36 +: 3]);
    end
  endtask
  task addresses;
    begin
      addr_one(8'h03, 24'h12_3456, 22'h12_3456);
      addr_one(8'h0b, 24'hff_ffff, 22'h3f_ffff);
      addr_one(8'h50, 24'hff_ffff, 22'h3f_f000);
      addr_one(8'h7c, 24'hff_ffff, 22'h3f_0000);
      addr_one(8'h81, 24'hff_ffff, 22'h3f_fe00);
      addr_one(8'h58, 24'hff_ffff, 22'h3f_fe00);
      addr_one(8'h77, 24'hff_ffff, 22'h00_0000);
      binary_page <= 1'b0;
      send_chk({8'h03, 1'b1, 13'h1555, 10'h2aa}, 32, 1'b1);
      check(cmd_page, 13'h1555, "page");
      check(cmd_byte, 10'h2aa, "byte");
      check(cmd_addr, 0, "address");
      binary_page <= 1'b1;
    end
  endtask
  // Fourth command breaks the other-buffer limit on purpose
  task concurrency;
    begin
      send_chk(32'h8600_0000, 32, 1'b1);
      check(active_group, 3'h2, "active");
      check(active_buf2, 1'b1, "active buffer");
      send_chk(32'h9f00_0000, 8, 1'b1);
      send_chk(32'h8400_0000, 32, 1'b1);
      send_chk(32'h8700_0000, 32, 1'b0);
      wait_idle;
      send_chk(32'h3d2a_7fcf, 32, 1'b1);
      check(active_group, 3'h4, "active");
      send_chk(32'h9f00_0000, 8, 1'b0);
      send_chk(32'h5700_0000, 8, 1'b1);
      wait_idle;
    end
  endtask
  task power;
    begin
      send_chk(32'hb900_0000, 8, 1'b1);
      check(powered_down, 1'b1, "asleep");
      send_chk(32'hd700_0000, 8, 1'b0);
      send_chk(32'hab00_0000, 8, 1'b1);
      check(powered_down, 1'b0, "asleep");
      send_chk(32'hd700_0000, 8, 1'b1);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    srst = 1'b1;
    binary_page = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    classify_all;
    addresses;
    concurrency;
    power;
    give_verdict;
  end
endmodule
bind sfd_decoder sfd_chk #(.BUSY_CYCLES(BUSY_CYCLES)) i_sfd_chk (.clk(clk), .srst(srst),
  .binary_page(binary_page), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_group(cmd_group),
  .cmd_buf2(cmd_buf2), .cmd_dummy(cmd_dummy), .cmd_addr(cmd_addr), .cmd_reject(cmd_reject), .busy(busy),
  .active_group(active_group), .active_buf2(active_buf2), .powered_down(powered_down));
